/* File: lmoc_defs.svh */
`ifndef LMOC_DEFS_SVH
`define LMOC_DEFS_SVH

`define LMOC_CMD_BITS      16
`define LMOC_CMD_RESTART   0
`define LMOC_CMD_RESET     1
`define LMOC_DISC_SHIFT    4
`define LMOC_STAT_ACTIVE   7
`define LMOC_STAT_MISSING  4
`define LMOC_FIFO_DEPTH    8
`define LMOC_NSLAVE        8
`define LMOC_IMAGE_WORDS   128

`endif

/* File: lmoc_link_model.sv */
`timescale 1ns/1ps
`default_nettype none

module lmoc_link_model
	import lmoc_pkg::*;
(
	input  wire logic       i_mclk,
	input  wire logic       i_stall,
	input  wire logic [7:0] i_power,
	output logic            o_tx_ready,
	output logic [7:0]      o_slave_ready
);
	import lmoc_pkg::*;
	logic [1:0] beat = 2'h0;
	logic [7:0] wake = 8'h00;

	// slow link: every fourth cycle refuses a word
	always_ff @(posedge i_mclk) begin
		beat <= beat + 2'h1;
		wake <= i_power;
		o_slave_ready <= wake & i_power;
	end
	assign o_tx_ready = !i_stall && (beat != 2'h3);
endmodule

`default_nettype wire

/* File: lmoc_master.sv */
`timescale 1ns/1ps
`default_nettype none
`include "lmoc_defs.svh"

module lmoc_fifo #(
	parameter int WIDTH = 19,
	parameter int DEPTH = `LMOC_FIFO_DEPTH
) (
	input  wire logic             i_mclk,
	input  wire logic             i_resetn,
	input  wire logic             i_in_valid,
	output logic                  o_in_ready,
	input  wire logic [WIDTH-1:0] i_in_data,
	output logic                  o_out_valid,
	input  wire logic             i_out_ready,
	output logic      [WIDTH-1:0] o_out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	logic             push;
	logic             pop;

	assign o_in_ready  = (count != (AW+1)'(DEPTH));
	assign o_out_valid = (count != '0);
	assign push        = i_in_valid && o_in_ready;
	assign pop         = o_out_valid && i_out_ready;
	assign o_out_data  = mem[rd_ptr];

	always_ff @(posedge i_mclk) begin
		if (push) begin
			mem[wr_ptr] <= i_in_data;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_resetn) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
			end
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

// Operation
// RULE1 - the first 16 bits of the output area are the module's own command word.
// RULE2 - slave output regions follow the command word in the same memory type, no gaps.
// RULE3 - each slave's start and length come from slave order and its configured width.
// RULE4 - in word memory the command is one word and slave 0 starts at the next word.
// RULE5 - only command bits 0 and 1 act; the other fourteen are ignored.
// RULE6 - bit 0 restarts the link like the restart button, only while it is not active.
// RULE7 - bit 1 resets the link only while it is active, ignored otherwise.
// RULE8 - a reset stops output transmission and clears the indicator and status bit 7; the fifo still sends up to FIFO_DEPTH words already queued.
// RULE9 - restart and reset are one-shots accepted in opposite states, so never conflict.
// RULE10 - the host holds restart low and pulses it one scan after repair and power-cycling.
// RULE11 - the host holds reset low and pulses it one scan to reset a running link.
// RULE12 - with restart held high, a link forms once slave 0 is ready, up to the first not ready.
// RULE13 - status bit 7 is 1 while the link is active and 0 once it fails.
// RULE14 - without fresh host outputs, data is zeroed or held per configuration and still sent.
// RULE15 - each command bit acts once per 0-to-1 transition, a held bit never retriggers.
module lmoc_master
	import lmoc_pkg::*;
#(
	parameter int NSLAVE      = `LMOC_NSLAVE,
	parameter int IMAGE_WORDS = `LMOC_IMAGE_WORDS,
	parameter int FIFO_DEPTH  = `LMOC_FIFO_DEPTH
) (
	input  wire logic                 i_mclk,
	input  wire logic                 i_resetn,
	input  wire lmoc_pkg::lmoc_cfg_t  i_cfg,
	input  wire logic                 i_host_run,
	input  wire logic                 i_out_wr,
	input  wire logic [15:0]          i_out_ref,
	input  wire logic [15:0]          i_out_data,
	input  wire logic                 i_restart_btn,
	input  wire logic [NSLAVE-1:0]    i_slave_ready,
	input  wire logic                 i_link_fault,
	output logic                      o_tx_valid,
	input  wire logic                 i_tx_ready,
	output lmoc_pkg::lmoc_txword_t    o_tx_word,
	output logic                      o_link_active_indicator,
	output logic [7:0]                o_status
);
	import lmoc_pkg::*;

	localparam int IAW = $clog2(IMAGE_WORDS);

	lmoc_state_t         state;
	logic [15:0]         link_command_word;
	logic [15:0]         image [IMAGE_WORDS];
	logic [15:0]         last_sent [IMAGE_WORDS];
	logic [NSLAVE-1:0]   ready_m;
	logic [NSLAVE-1:0]   ready_s;
	logic [1:0]          btn_m;
	logic [1:0]          fault_m;
	logic                btn_s;
	logic                fault_s;
	logic                btn_q;
	logic [3:0]          n_linked;
	logic [2:0]          scan_slave;
	logic [3:0]          scan_word;
	logic [15:0]         rel;
	logic [15:0]         word_idx;
	logic                ref_ok;
	logic                cmd_wr;
	logic                data_wr;
	logic                restart_req;
	logic                reset_req;
	logic [IAW-1:0]      rd_addr;
	lmoc_txword_t        push_word;
	logic                push_valid;
	logic                push_ready;

	// word index of slave s counted from the command word
	function automatic logic [7:0] slave_start(input lmoc_cfg_t c, input logic [2:0] s);
		logic [7:0] acc;
		acc = 8'h01;
		for (int k = 0; k < 8; k++) begin
			if (3'(k) < s) begin
				acc = acc + {4'h0, c.slave_words[k]};
			end
		end
		return acc;
	endfunction

	function automatic logic [3:0] count_ready(input logic [NSLAVE-1:0] r, input logic [3:0] lim);
		logic [3:0] n;
		logic       run;
		n   = 4'h0;
		run = 1'b1;
		for (int k = 0; k < NSLAVE; k++) begin
			run = run && r[k] && (4'(k) < lim);
			if (run) begin
				n = n + 4'h1;
			end
		end
		return n;
	endfunction

	// pin inputs: first stage read only by the second
	always_ff @(posedge i_mclk) begin
		if (!i_resetn) begin
			ready_m <= '0;
			ready_s <= '0;
			btn_m   <= '0;
			fault_m <= '0;
		end else begin
			ready_m <= i_slave_ready;
			ready_s <= ready_m;
			btn_m   <= {btn_m[0], i_restart_btn};
			fault_m <= {fault_m[0], i_link_fault};
		end
	end
	assign btn_s   = btn_m[1];
	assign fault_s = fault_m[1];

	// discrete refs count bits, word refs count words
	assign rel      = i_out_ref - i_cfg.base_ref;
	assign word_idx = i_cfg.mem_word ? rel : (rel >> `LMOC_DISC_SHIFT); // [RULE2] [RULE4]
	assign ref_ok   = (i_out_ref >= i_cfg.base_ref) &&
		(i_cfg.mem_word || rel[`LMOC_DISC_SHIFT-1:0] == '0);
	// host writes only count while it is running
	assign cmd_wr  = i_out_wr && i_host_run && ref_ok && (word_idx == 16'h0000); // [RULE1]
	assign data_wr = i_out_wr && i_host_run && ref_ok && (word_idx != 16'h0000) &&
		(word_idx <= 16'(IMAGE_WORDS));

	// rising edges only; bits 2..15 feed nothing
	assign restart_req = (cmd_wr && i_out_data[`LMOC_CMD_RESTART] &&
		!link_command_word[`LMOC_CMD_RESTART]) || (btn_s && !btn_q); // [RULE15] [RULE5] [RULE6]
	assign reset_req = cmd_wr && i_out_data[`LMOC_CMD_RESET] &&
		!link_command_word[`LMOC_CMD_RESET]; // [RULE15] [RULE5]

	always_ff @(posedge i_mclk) begin
		if (!i_resetn) begin
			link_command_word <= '0;
			btn_q             <= 1'b0;
		end else begin
			btn_q <= btn_s;
			if (cmd_wr) begin
				link_command_word <= i_out_data;
			end
		end
	end

	always_ff @(posedge i_mclk) begin
		if (data_wr) begin
			image[IAW'(word_idx - 16'h0001)] <= i_out_data; // [RULE2]
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_resetn) begin
			state    <= LMOC_ST_IDLE;
			n_linked <= '0;
		end else begin
			case (state)
			LMOC_ST_IDLE: begin
				if (restart_req) begin
					state <= LMOC_ST_FORM; // [RULE6]
				end
			end
			LMOC_ST_FORM: begin
				if (ready_s[0]) begin
					state    <= LMOC_ST_LINK_ACTIVE_INDICATOR;
					n_linked <= count_ready(ready_s, i_cfg.n_slaves); // [RULE12]
				end else if (!link_command_word[`LMOC_CMD_RESTART] && !btn_s) begin
					state <= LMOC_ST_IDLE;
				end
			end
			LMOC_ST_LINK_ACTIVE_INDICATOR: begin
				// restart is not looked at here, so the two never collide
				if (reset_req || fault_s) begin
					state <= LMOC_ST_IDLE; // [RULE7] [RULE9] [RULE13]
				end
			end
			default: state <= LMOC_ST_IDLE;
			endcase
		end
	end

	assign o_link_active_indicator = (state == LMOC_ST_LINK_ACTIVE_INDICATOR); // [RULE8]
	// bit 4: fewer slaves linked than configured while active, bits 3..0: number of slaves linked
	assign o_status = {o_link_active_indicator, 2'b00,
		o_link_active_indicator && (n_linked < i_cfg.n_slaves), n_linked}; // [RULE13]

	// scan walks slaves in order, word by word, only while active
	assign rd_addr    = IAW'(slave_start(i_cfg, scan_slave) + {4'h0, scan_word} - 8'h01); // [RULE3]
	assign push_valid = o_link_active_indicator &&
		(i_cfg.slave_words[scan_slave] != 4'h0); // [RULE8]
	assign push_word.slave = scan_slave;
	assign push_word.data  = i_host_run ? image[rd_addr] :
		(i_cfg.hold_last ? last_sent[rd_addr] : 16'h0000); // [RULE14]

	always_ff @(posedge i_mclk) begin
		if (push_valid && push_ready && i_host_run) begin
			last_sent[rd_addr] <= image[rd_addr];
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_resetn || !o_link_active_indicator) begin
			scan_slave <= '0;
			scan_word  <= '0;
		end else if (!push_valid || push_ready) begin
			if (!push_valid || scan_word == i_cfg.slave_words[scan_slave] - 4'h1) begin
				scan_word  <= '0;
				scan_slave <= ({1'b0, scan_slave} + 4'h1 >= n_linked) ? 3'h0 :
					scan_slave + 3'h1; // [RULE3]
			end else begin
				scan_word <= scan_word + 4'h1;
			end
		end
	end

	// back-pressure from the link stalls the scan
	lmoc_fifo #(
		.WIDTH ($bits(lmoc_txword_t)),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.i_mclk      (i_mclk),
		.i_resetn    (i_resetn),
		.i_in_valid  (push_valid),
		.o_in_ready  (push_ready),
		.i_in_data   (push_word),
		.o_out_valid (o_tx_valid),
		.i_out_ready (i_tx_ready),
		.o_out_data  (o_tx_word)
	);

	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_resetn);

	chk_reset_stops_link: assert property ( // [RULE8]
		reset_req && state == LMOC_ST_LINK_ACTIVE_INDICATOR |=> !o_link_active_indicator && !o_status[7])
		else $error("reset command did not stop the link");
	chk_restart_when_active: assert property ( // [RULE6]
		restart_req && !reset_req && state == LMOC_ST_LINK_ACTIVE_INDICATOR && !fault_s |=> state == LMOC_ST_LINK_ACTIVE_INDICATOR)
		else $error("restart acted on an active link");
	chk_reset_when_idle: assert property ( // [RULE7]
		reset_req && state == LMOC_ST_IDLE && !restart_req |=> state == LMOC_ST_IDLE)
		else $error("reset acted on an idle link");
	chk_no_send_idle: assert property ( // [RULE8]
		!o_link_active_indicator |=> u_fifo.count <= $past(u_fifo.count))
		else $error("outputs pushed while link inactive");
	chk_held_bit_quiet: assert property ( // [RULE15]
		cmd_wr && link_command_word[0] && !(btn_s && !btn_q) |-> !restart_req)
		else $error("held restart bit retriggered");
	chk_zero_default: assert property ( // [RULE14]
		push_valid && !i_host_run && !i_cfg.hold_last |-> push_word.data == 16'h0000)
		else $error("stale outputs not zeroed");
	chk_form_slave0: assert property ( // [RULE12]
		state == LMOC_ST_FORM && ready_s[0] |=> state == LMOC_ST_LINK_ACTIVE_INDICATOR && n_linked != 4'h0)
		else $error("link not formed on slave 0 ready");
	chk_fault_clears: assert property ( // [RULE13]
		state == LMOC_ST_LINK_ACTIVE_INDICATOR && fault_s |=> ##[0:1] !o_status[7])
		else $error("link fault left status bit 7 set");
	chk_slave_order: assert property ( // [RULE3]
		push_valid && push_ready && scan_word == 4'h0 && $past(push_valid && push_ready) &&
		$past(scan_word) == 4'h0 && i_cfg.slave_words[$past(scan_slave)] == 4'h1 &&
		$past(scan_slave) != scan_slave |->
		scan_slave == 3'h0 || scan_slave == $past(scan_slave) + 3'h1)
		else $error("slaves scanned out of order");
endmodule
`default_nettype wire

/* File: lmoc_pkg.sv */
package lmoc_pkg;

	typedef enum logic [2:0] {
		LMOC_ST_IDLE = 3'b001,
		LMOC_ST_FORM = 3'b010,
		LMOC_ST_LINK_ACTIVE_INDICATOR = 3'b100
	} lmoc_state_t;

	// per-slave width in 16-bit words, slave 0 in the low nibble
	typedef struct packed {
		logic            mem_word;
		logic            hold_last;
		logic [3:0]      n_slaves;
		logic [15:0]     base_ref;
		logic [7:0][3:0] slave_words;
	} lmoc_cfg_t;

	typedef struct packed {
		logic [2:0]  slave;
		logic [15:0] data;
	} lmoc_txword_t;

endpackage

/* File: tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	import lmoc_pkg::*;
	typedef struct {logic [15:0] off; logic [15:0] data; logic [2:0] slave;} lmoc_row_t;
	logic         i_mclk, i_resetn, i_host_run, i_out_wr, i_restart_btn, i_link_fault, stall;
	logic [15:0]  i_out_ref, i_out_data;
	logic [7:0]   power, rdy, o_status;
	lmoc_cfg_t    cfg;
	logic         o_tx_valid, tx_ready, ind;
	lmoc_txword_t o_tx_word, held;
	int           fails, checks_done, k;
	lmoc_txword_t cap[$];
	lmoc_row_t    rows[5] = '{'{1, 16'h1111, 0}, '{2, 16'h2222, 0}, '{3, 16'h3333, 0},
		'{4, 16'h4444, 0}, '{5, 16'h5555, 1}};

	lmoc_master i_lmoc_master (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_cfg(cfg),
		.i_host_run(i_host_run), .i_out_wr(i_out_wr), .i_out_ref(i_out_ref),
		.i_out_data(i_out_data), .i_restart_btn(i_restart_btn), .i_slave_ready(rdy),
		.i_link_fault(i_link_fault), .o_tx_valid(o_tx_valid), .i_tx_ready(tx_ready),
		.o_tx_word(o_tx_word), .o_link_active_indicator(ind), .o_status(o_status));
	lmoc_link_model i_lmoc_link_model (.i_mclk(i_mclk), .i_stall(stall), .i_power(power),
		.o_tx_ready(tx_ready), .o_slave_ready(rdy));

	initial begin
		i_mclk = 1'b0;
		forever #50 i_mclk = ~i_mclk;
	end
	always @(posedge i_mclk) if (o_tx_valid === 1'b1 && tx_ready) cap.push_back(o_tx_word);

	task automatic results();
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [15:0] off, input logic [15:0] d);
		i_out_wr <= 1'b1;
		i_out_ref <= cfg.base_ref + off;
		i_out_data <= d;
		@(posedge i_mclk);
		i_out_wr <= 1'b0;
		@(posedge i_mclk);
	endtask
	task automatic wait_ind(input logic v);
		for (int n = 0; n < 60 && ind !== v; n++) @(posedge i_mclk);
	endtask
	task automatic rst(input logic mw, input logic [15:0] b, input logic [3:0] n,
		input logic [31:0] w);
		i_resetn <= 1'b0;
		cfg <= '{mem_word: mw, hold_last: 1'b0, n_slaves: n, base_ref: b, slave_words: w};
		repeat (8) @(posedge i_mclk);
		i_resetn <= 1'b1;
		@(posedge i_mclk);
	endtask
	// settle the fifo of stale words, then catch n fresh ones
	task automatic grab(input int n);
		repeat (30) @(posedge i_mclk);
		cap.delete();
		for (int c = 0; c < 300 && cap.size() < n; c++) @(posedge i_mclk);
	endtask

	initial begin
		repeat (20000) @(posedge i_mclk);
		fails++;
		results();
	end

	initial begin
		{i_out_wr, i_restart_btn, i_link_fault, stall} <= '0;
		{i_host_run, power, i_out_ref, i_out_data} <= {1'b1, 8'hFF, 32'h0};
		{fails, checks_done, k} = '0;
		rst(1'b1, 16'h0006, 4'h2, 32'h14);
		chk("status", o_status, 0);
		chk("valid", o_tx_valid, 0);
		wr(0, 16'h0001);
		wait_ind(1);
		chk("status", o_status, 16'h82);
		foreach (rows[i]) wr(rows[i].off, rows[i].data);
		grab(12);
		for (int i = 1; i < 7; i++) if (k == 0 && cap[i].slave == 0 && cap[i-1].slave != 0) k = i;
		foreach (rows[i]) begin
			chk("data", cap[k+i].data, rows[i].data);
			chk("slave", 16'(cap[k+i].slave), 16'(rows[i].slave));
		end
		chk("wrap", 16'(cap[k+5].slave), 0);
		stall <= 1'b1;
		repeat (20) @(posedge i_mclk);
		held = o_tx_word;
		repeat (5) @(posedge i_mclk);
		chk("stand", o_tx_word.data, held.data);
		stall <= 1'b0;
		wr(0, 16'h0000);
		wr(0, 16'hFFFD);
		chk("ind", ind, 1);
		wr(0, 16'h0002);
		chk("ind", ind, 0);
		chk("stat7", o_status[7], 0);
		repeat (20) @(posedge i_mclk);
		cap.delete();
		repeat (20) @(posedge i_mclk);
		chk("pops", 16'(cap.size()), 0);
		wr(0, 16'h0003);
		wait_ind(1);
		chk("ind", ind, 1);
		wr(0, 16'h0002);
		chk("ind", ind, 1);
		wr(0, 16'h0000);
		wr(0, 16'h0002);
		wr(0, 16'h0000);
		wr(0, 16'h0002);
		chk("ind", ind, 0);
		wr(0, 16'h0001);
		wait_ind(1);
		chk("ind", ind, 1);
		i_link_fault <= 1'b1;
		repeat (6) @(posedge i_mclk);
		chk("stat7", o_status[7], 0);
		i_link_fault <= 1'b0;
		i_restart_btn <= 1'b1;
		repeat (4) @(posedge i_mclk);
		i_restart_btn <= 1'b0;
		wait_ind(1);
		chk("ind", ind, 1);
		i_host_run <= 1'b0;
		wr(1, 16'hBEEF);
		grab(6);
		for (int i = 0; i < 6; i++) chk("zero", cap[i].data, 0);
		i_host_run <= 1'b1;
		power <= 8'h00;
		wr(0, 16'h0002);
		repeat (3) @(posedge i_mclk);
		wr(0, 16'h0001);
		repeat (10) @(posedge i_mclk);
		chk("ind", ind, 0);
		power <= 8'h01;
		wait_ind(1);
		chk("status", o_status, 16'h91);
		power <= 8'hFF;
		rst(1'b0, 16'h0191, 4'h1, 32'h4);
		wr(0, 16'h0001);
		wait_ind(1);
		wr(16, 16'hA5A5);
		wr(8, 16'h5A5A);
		wr(32, 16'h0F0F);
		grab(8);
		k = 0;
		for (int i = 0; i < 4; i++) if (cap[i].data == 16'hA5A5) k = i;
		chk("disc0", cap[k].data, 16'hA5A5);
		chk("disc1", cap[k+1].data, 16'h0F0F);
		results();
	end
endmodule

`default_nettype wire
